//--- hw/rcr_pkg.sv
// Purpose: Constants and types for the regulator control register bank
// Assumes: Byte-wide registers reached through the serial engine's register port
// Notes:   All numbers used by the logic are named here
package rcr_pkg;

  localparam logic [7:0] ADDR_SUPPLY_ENABLE   = 8'h03;
  localparam logic [7:0] ADDR_CONVERTER_MODE  = 8'h04;
  localparam logic [7:0] ADDR_CONVERTER_TWO   = 8'h05;
  localparam logic [7:0] ADDR_CORE_CODE       = 8'h06;
  localparam logic [7:0] ADDR_CORE_SLEW       = 8'h07;

  localparam logic [7:0] RST_SUPPLY_ENABLE    = 8'hFF;
  localparam logic [7:0] RST_CONVERTER_MODE   = 8'hB1;
  localparam logic [7:0] RST_CONVERTER_TWO    = 8'h40;
  localparam logic [2:0] RST_CORE_SLEW        = 3'h6;

  // Writable masks; other positions ignore writes and read zero
  localparam logic [7:0] MASK_SUPPLY_ENABLE   = 8'h3E;
  localparam logic [7:0] MASK_CONVERTER_TWO   = 8'hC7;
  localparam logic [7:0] MASK_CORE_CODE       = 8'h1F;
  localparam logic [7:0] MASK_CORE_SLEW       = 8'h07;

  // Supply enable bit positions
  localparam int EN_BUCK1 = 5;
  localparam int EN_BUCK2 = 4;
  localparam int EN_BUCK3 = 3;
  localparam int EN_SECOND_LINEAR_REGULATOR  = 2;
  localparam int EN_FIRST_LINEAR_REGULATOR  = 1;

  // Converter mode fields
  localparam int MODE_B2_PH_HI = 7;
  localparam int MODE_B2_PH_LO = 6;
  localparam int MODE_B3_PH_HI = 5;
  localparam int MODE_B3_PH_LO = 4;
  localparam int MODE_RIPPLE   = 3;
  localparam int MODE_FORCED_PWM_B2  = 2;
  localparam int MODE_FORCED_PWM_B1  = 1;
  localparam int MODE_FORCED_PWM_B3  = 0;

  // Converter control two fields
  localparam int CTL_GO        = 7;
  localparam int CTL_PIN_SEL   = 6;
  localparam int CTL_DIS_B2    = 2;
  localparam int CTL_DIS_B1    = 1;
  localparam int CTL_DIS_B3    = 0;

  // Core code defaults: msb always set, low nibble from strap
  localparam logic [4:0] CORE_CODE_LOW_STRAP  = 5'h14;
  localparam logic [4:0] CORE_CODE_HIGH_STRAP = 5'h1E;

  // Phase delay of buck1 is fixed at zero quarters
  localparam logic [1:0] PHASE_REFERENCE = 2'h0;

  // Slew: time for one code step per setting, in ns (25 mV / rate)
  localparam int CLK_PERIOD_NS = 40;
  localparam int SLEW_STEP_NS [8] = '{111111, 55555, 27777, 13888, 6944, 3472, 1736, 40};

  typedef enum logic [1:0] {
    RCR_IDLE = 2'b00,
    RCR_STEP = 2'b01,
    RCR_WAIT = 2'b10
  } rcr_dvm_state_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rcr_reg_req_t;

  typedef struct packed {
    logic       buck1_on;
    logic       buck2_on;
    logic       buck3_on;
    logic       first_linear_regulator_on;
    logic       second_linear_regulator_on;
  } rcr_supply_on_t;

  typedef struct packed {
    logic [1:0] buck1_phase;
    logic [1:0] buck2_phase;
    logic [1:0] buck3_phase;
    logic       low_ripple;
    logic [2:0] forced_pwm;
    logic [2:0] discharge;
  } rcr_conv_cfg_t;

endpackage : rcr_pkg

//--- hw/rcr_step_timer.sv
// Purpose: Paces voltage code steps at the selected slew setting
// Assumes: Reloaded while run is low, counts every clock
// Notes:   Tick is one cycle wide, except at slew setting 7 where it stays high every running cycle
`timescale 1ns/100ps
module rcr_step_timer #(
  parameter int CNT_W = 12
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       run,
  input  wire logic [2:0] slew_sel,
  // Step tick
  output logic            tick
);

  function automatic logic [CNT_W-1:0] step_cycles(input logic [2:0] sel);
    int n;
    n = rcr_pkg::SLEW_STEP_NS[sel] / rcr_pkg::CLK_PERIOD_NS;
    if (n < 1) begin
      n = 1;
    end
    return CNT_W'(n - 1);
  endfunction : step_cycles

  logic [CNT_W-1:0] count;

  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      count <= step_cycles(slew_sel);
      tick  <= 1'b0;
    end else if (count == '0) begin
      count <= step_cycles(slew_sel);
      tick  <= 1'b1;
    end else begin
      count <= count - CNT_W'(1);
      tick  <= 1'b0;
    end
  end

endmodule : rcr_step_timer

//--- hw/rcr_regulator_control.sv
// Purpose: Supply enables, converter mode, converter control and core voltage code registers
// Assumes: Serial engine hands over byte writes and reads on a synchronous register port
// Notes:   Lockout arrives as a synchronous active-high level, warm reset as an active-low pin
`timescale 1ns/100ps

// Operation
// - buck3 on needs bit 3 and pin
// - second LDO needs bit 2 and pin
// - first LDO needs bit 1 and pin
// - Lockout sets enable bits; writes otherwise
// - Low enable pin forces bit to one
// - Mode register at 04h, reset B1h
// - Phase delay fields for buck2, buck3
// - buck1 phase fixed at zero
// - Bit 3 selects low ripple PFM
// - Forced PWM bits per converter
// - Control two at 05h, reset 40h
// - Go bit starts stepping toward code
// - Go clears when code reaches target
// - Pin select chooses pin or register
// - Four events restore pin select
// - Discharge bits per disabled converter
// - Core code at 06h, strap default
// - Four events reload core code
// - Enable register 03h, reset FFh
module rcr_regulator_control #(
  parameter int TIMER_W = 12
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // Reset events
  input  wire logic                    undervoltage_lockout,
  input  wire logic                    warm_reset_pin_n,
  input  wire logic                    power_on_reset_out,
  input  wire logic                    rtc_supply_low,
  // Straps and enable pins
  input  wire logic                    core_default_pin,
  input  wire logic                    buck1_enable_pin,
  input  wire logic                    buck2_enable_pin,
  input  wire logic                    buck3_enable_pin,
  input  wire logic                    ldo_shared_enable_pin,
  // Register port
  input  wire rcr_pkg::rcr_reg_req_t   reg_req,
  output logic [7:0]                   reg_rdata,
  // Supply controls
  output rcr_pkg::rcr_supply_on_t      supply_on,
  output rcr_pkg::rcr_conv_cfg_t       conv_cfg,
  output logic                         core_use_pin,
  output logic [4:0]                   core_step_code,
  output logic                         core_dvm_busy
);

  logic [7:0]                   supply_enable_control;
  logic [7:0]                   converter_mode_control;
  logic [7:0]                   converter_control_two;
  logic [4:0]                   core_voltage_code;
  logic [2:0]                   core_slew_select;
  logic                         core_strap;
  logic                         strap_seen;
  rcr_pkg::rcr_dvm_state_t      dvm_state;
  rcr_pkg::rcr_dvm_state_t      next_dvm_state;
  logic                         step_tick;
  logic                         core_reset_evt;
  logic                         wr_enable;
  logic                         wr_mode;
  logic                         wr_two;
  logic                         wr_code;
  logic                         wr_slew;
  logic                         go_done;
  logic [7:0]                   next_supply;
  logic [7:0]                   next_rdata;

  function automatic logic hit(input rcr_pkg::rcr_reg_req_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction : hit

  function automatic logic [4:0] core_default(input logic strap);
    return strap ? rcr_pkg::CORE_CODE_HIGH_STRAP : rcr_pkg::CORE_CODE_LOW_STRAP;
  endfunction : core_default

  assign wr_enable      = hit(reg_req, rcr_pkg::ADDR_SUPPLY_ENABLE);
  assign wr_mode        = hit(reg_req, rcr_pkg::ADDR_CONVERTER_MODE);
  assign wr_two         = hit(reg_req, rcr_pkg::ADDR_CONVERTER_TWO);
  assign wr_code        = hit(reg_req, rcr_pkg::ADDR_CORE_CODE);
  assign wr_slew        = hit(reg_req, rcr_pkg::ADDR_CORE_SLEW);
  assign core_reset_evt = undervoltage_lockout || !warm_reset_pin_n
                          || power_on_reset_out || rtc_supply_low;

  // Strap caught by a clocked process after reset release, held till next core reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strap_seen <= 1'b0;
      core_strap <= 1'b0;
    end else if (core_reset_evt || !strap_seen) begin
      strap_seen <= 1'b1;
      core_strap <= core_default_pin;
    end
  end

  // Supply enables: pin-low restore wins over a serial write
  always_comb begin
    next_supply = supply_enable_control;
    if (wr_enable) begin
      next_supply = (reg_req.wdata & rcr_pkg::MASK_SUPPLY_ENABLE)
                    | ~rcr_pkg::MASK_SUPPLY_ENABLE;
    end
    if (!buck1_enable_pin) next_supply[rcr_pkg::EN_BUCK1] = 1'b1;
    if (!buck2_enable_pin) next_supply[rcr_pkg::EN_BUCK2] = 1'b1;
    if (!buck3_enable_pin) next_supply[rcr_pkg::EN_BUCK3] = 1'b1;
    if (!ldo_shared_enable_pin) begin
      next_supply[rcr_pkg::EN_SECOND_LINEAR_REGULATOR] = 1'b1;
      next_supply[rcr_pkg::EN_FIRST_LINEAR_REGULATOR] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || undervoltage_lockout) begin
      supply_enable_control <= rcr_pkg::RST_SUPPLY_ENABLE;
    end else begin
      supply_enable_control <= next_supply;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || undervoltage_lockout) begin
      converter_mode_control <= rcr_pkg::RST_CONVERTER_MODE;
    end else if (wr_mode) begin
      converter_mode_control <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || undervoltage_lockout) begin
      core_slew_select <= rcr_pkg::RST_CORE_SLEW;
    end else if (wr_slew) begin
      core_slew_select <= reg_req.wdata[2:0];
    end
  end

  // Converter control two: go and discharge reset on lockout, pin select on any of the four core reset events
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      converter_control_two <= rcr_pkg::RST_CONVERTER_TWO;
    end else begin
      if (undervoltage_lockout) begin
        converter_control_two[rcr_pkg::CTL_GO]     <= rcr_pkg::RST_CONVERTER_TWO[rcr_pkg::CTL_GO];
        converter_control_two[rcr_pkg::CTL_DIS_B2:0] <= rcr_pkg::RST_CONVERTER_TWO[rcr_pkg::CTL_DIS_B2:0];
      end else if (wr_two) begin
        // Writing zero to go leaves a running transition alone
        converter_control_two[rcr_pkg::CTL_GO] <= reg_req.wdata[rcr_pkg::CTL_GO]
                                                  || (converter_control_two[rcr_pkg::CTL_GO] && !go_done);
        converter_control_two[rcr_pkg::CTL_DIS_B2:0] <= reg_req.wdata[rcr_pkg::CTL_DIS_B2:0];
      end else if (go_done) begin
        converter_control_two[rcr_pkg::CTL_GO] <= 1'b0;
      end
      if (core_reset_evt) begin
        converter_control_two[rcr_pkg::CTL_PIN_SEL] <= rcr_pkg::RST_CONVERTER_TWO[rcr_pkg::CTL_PIN_SEL];
      end else if (wr_two) begin
        converter_control_two[rcr_pkg::CTL_PIN_SEL] <= reg_req.wdata[rcr_pkg::CTL_PIN_SEL];
      end
      converter_control_two[5:3] <= 3'h0;
    end
  end

  // Core code: one cycle after reset release it takes the strap default
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_voltage_code <= rcr_pkg::CORE_CODE_LOW_STRAP;
    end else if (core_reset_evt || !strap_seen) begin
      core_voltage_code <= core_default(core_default_pin);
    end else if (wr_code) begin
      core_voltage_code <= reg_req.wdata[4:0];
    end
  end

  // Voltage change stepping
  rcr_step_timer #(
    .CNT_W    (TIMER_W)
  ) u_step_timer (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .run      (dvm_state == rcr_pkg::RCR_STEP),
    .slew_sel (core_slew_select),
    .tick     (step_tick)
  );

  assign go_done = (dvm_state == rcr_pkg::RCR_WAIT);

  always_comb begin
    next_dvm_state = dvm_state;
    case (dvm_state)
      rcr_pkg::RCR_IDLE: begin
        if (converter_control_two[rcr_pkg::CTL_GO]) begin
          next_dvm_state = rcr_pkg::RCR_STEP;
        end
      end
      rcr_pkg::RCR_STEP: begin
        if (core_step_code == core_voltage_code) begin
          next_dvm_state = rcr_pkg::RCR_WAIT;
        end
      end
      rcr_pkg::RCR_WAIT: begin
        next_dvm_state = rcr_pkg::RCR_IDLE;
      end
      default: begin
        next_dvm_state = rcr_pkg::RCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst || undervoltage_lockout) begin
      dvm_state <= rcr_pkg::RCR_IDLE;
    end else begin
      dvm_state <= next_dvm_state;
    end
  end

  // Stepped code follows target one code per tick while stepping; otherwise holds, reloaded with the strap default on core reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_step_code <= rcr_pkg::CORE_CODE_LOW_STRAP;
    end else if (core_reset_evt || !strap_seen) begin
      core_step_code <= core_default(core_default_pin);
    end else if (dvm_state == rcr_pkg::RCR_STEP && step_tick) begin
      if (core_step_code < core_voltage_code) begin
        core_step_code <= core_step_code + 5'h01;
      end else if (core_step_code > core_voltage_code) begin
        core_step_code <= core_step_code - 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_dvm_busy <= 1'b0;
    end else begin
      core_dvm_busy <= (next_dvm_state == rcr_pkg::RCR_STEP);
    end
  end

  // Supply gating: register bit and pin must both be high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      supply_on <= '0;
    end else begin
      supply_on.buck1_on <= supply_enable_control[rcr_pkg::EN_BUCK1] && buck1_enable_pin;
      supply_on.buck2_on <= supply_enable_control[rcr_pkg::EN_BUCK2] && buck2_enable_pin;
      supply_on.buck3_on <= supply_enable_control[rcr_pkg::EN_BUCK3] && buck3_enable_pin;
      supply_on.second_linear_regulator_on  <= supply_enable_control[rcr_pkg::EN_SECOND_LINEAR_REGULATOR] && ldo_shared_enable_pin;
      supply_on.first_linear_regulator_on  <= supply_enable_control[rcr_pkg::EN_FIRST_LINEAR_REGULATOR] && ldo_shared_enable_pin;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_cfg     <= '0;
      core_use_pin <= 1'b1;
    end else begin
      conv_cfg.buck1_phase <= rcr_pkg::PHASE_REFERENCE;
      conv_cfg.buck2_phase <= converter_mode_control[rcr_pkg::MODE_B2_PH_HI:rcr_pkg::MODE_B2_PH_LO];
      conv_cfg.buck3_phase <= converter_mode_control[rcr_pkg::MODE_B3_PH_HI:rcr_pkg::MODE_B3_PH_LO];
      conv_cfg.low_ripple  <= converter_mode_control[rcr_pkg::MODE_RIPPLE];
      // Order buck2, buck1, buck3
      conv_cfg.forced_pwm  <= converter_mode_control[rcr_pkg::MODE_FORCED_PWM_B2:rcr_pkg::MODE_FORCED_PWM_B3];
      // Discharge acts only while the converter is off
      conv_cfg.discharge   <= converter_control_two[rcr_pkg::CTL_DIS_B2:rcr_pkg::CTL_DIS_B3]
                              & ~{supply_on.buck2_on, supply_on.buck1_on, supply_on.buck3_on};
      core_use_pin         <= converter_control_two[rcr_pkg::CTL_PIN_SEL];
    end
  end

  // Read path, registered; unmapped addresses read zero
  always_comb begin
    case (reg_req.addr)
      rcr_pkg::ADDR_SUPPLY_ENABLE:  next_rdata = supply_enable_control & rcr_pkg::MASK_SUPPLY_ENABLE;
      rcr_pkg::ADDR_CONVERTER_MODE: next_rdata = converter_mode_control;
      rcr_pkg::ADDR_CONVERTER_TWO:  next_rdata = converter_control_two & rcr_pkg::MASK_CONVERTER_TWO;
      rcr_pkg::ADDR_CORE_CODE:      next_rdata = {3'h0, core_voltage_code};
      rcr_pkg::ADDR_CORE_SLEW:      next_rdata = {5'h00, core_slew_select};
      default:                      next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule : rcr_regulator_control

//--- tb/rcr_regulator_control_sva.sv
// Purpose: Port-level checks of the regulator control register bank
// Assumes: One clock, sys_rst synchronous and active high
// Notes:   Bound to the design top; sees its ports only
`timescale 1ns/100ps
module rcr_regulator_control_chk #(
  parameter int TIMER_W = 12
) (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    sys_rst,
  // Reset events and pins
  input wire logic                    undervoltage_lockout,
  input wire logic                    warm_reset_pin_n,
  input wire logic                    power_on_reset_out,
  input wire logic                    rtc_supply_low,
  input wire logic                    buck1_enable_pin,
  input wire logic                    buck3_enable_pin,
  input wire logic                    ldo_shared_enable_pin,
  // Register port and outputs
  input wire rcr_pkg::rcr_reg_req_t   reg_req,
  input wire rcr_pkg::rcr_supply_on_t supply_on,
  input wire rcr_pkg::rcr_conv_cfg_t  conv_cfg,
  input wire logic                    core_use_pin,
  input wire logic [4:0]              core_step_code,
  input wire logic                    core_dvm_busy
);
  wire core_event = undervoltage_lockout || !warm_reset_pin_n || power_on_reset_out || rtc_supply_low;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence go_write;
    reg_req.wr && reg_req.addr == 8'h05 && reg_req.wdata[7] && !undervoltage_lockout;
  endsequence
  sequence pin_back_high;
    !buck1_enable_pin ##1 (buck1_enable_pin && !reg_req.wr);
  endsequence

  chk_buck3_and_pin: assert property (supply_on.buck3_on |-> $past(buck3_enable_pin))
    else $error("buck3 on without its pin");
  chk_second_linear_regulator_and_pin: assert property (supply_on.second_linear_regulator_on |-> $past(ldo_shared_enable_pin))
    else $error("second regulator on without its pin");
  chk_first_linear_regulator_and_pin: assert property (supply_on.first_linear_regulator_on |-> $past(ldo_shared_enable_pin))
    else $error("first regulator on without its pin");
  chk_pin_restore_on: assert property (pin_back_high |=> supply_on.buck1_on)
    else $error("enable bit not restored by low pin");
  chk_mode_write_follow: assert property (reg_req.wr && reg_req.addr == 8'h04 && !undervoltage_lockout |-> ##2
    {conv_cfg.buck2_phase, conv_cfg.buck3_phase, conv_cfg.low_ripple, conv_cfg.forced_pwm} == $past(reg_req.wdata, 2))
    else $error("mode outputs do not follow write");
  chk_phase_ref_zero: assert property (conv_cfg.buck1_phase == 2'h0)
    else $error("buck1 phase not zero");
  chk_sel_event_restore: assert property (core_event |-> ##2 core_use_pin)
    else $error("pin select not restored by reset event");
  chk_go_starts_busy: assert property (go_write |-> ##[1:3] core_dvm_busy)
    else $error("go write did not start stepping");
  // A core reset event reloads the stepped code, so that cycle may jump
  chk_step_one_code: assert property (core_dvm_busy && $past(core_dvm_busy) && !$past(core_event)
    && $changed(core_step_code) |->
    (5'(core_step_code - $past(core_step_code)) inside {5'h01, 5'h1F}))
    else $error("step code moved by more than one");
endmodule : rcr_regulator_control_chk

bind rcr_regulator_control rcr_regulator_control_chk #(
  .TIMER_W(TIMER_W)
) u_chk (
  .clk                  (clk),
  .sys_rst              (sys_rst),
  .undervoltage_lockout (undervoltage_lockout),
  .warm_reset_pin_n     (warm_reset_pin_n),
  .power_on_reset_out   (power_on_reset_out),
  .rtc_supply_low       (rtc_supply_low),
  .buck1_enable_pin     (buck1_enable_pin),
  .buck3_enable_pin     (buck3_enable_pin),
  .ldo_shared_enable_pin(ldo_shared_enable_pin),
  .reg_req              (reg_req),
  .supply_on            (supply_on),
  .conv_cfg             (conv_cfg),
  .core_use_pin         (core_use_pin),
  .core_step_code       (core_step_code),
  .core_dvm_busy        (core_dvm_busy)
);

//--- tb/rcr_host.sv
// Purpose: Host side of the register port, as the serial engine hands it over
// Assumes: Writes are one-cycle strobes; read data one cycle after the address
// Notes:   Released write data is inverted so stale values never look valid
`timescale 1ns/100ps
module rcr_host (
  // Clock
  input  wire logic             clk,
  // Register port
  output rcr_pkg::rcr_reg_req_t reg_req,
  input  wire logic [7:0]       reg_rdata
);
  logic [7:0] got_data;
  event       got;

  initial reg_req = '0;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req.wr    <= 1'b1;
    reg_req.addr  <= a;
    reg_req.wdata <= d;
    @(posedge clk);
    reg_req.wr    <= 1'b0;
    reg_req.wdata <= ~d;
  endtask : wr

  // Sampled at the falling edge, well after the registered data settles
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_req.addr <= a;
    @(posedge clk);
    @(negedge clk);
    got_data = reg_rdata;
    -> got;
  endtask : rd
endmodule : rcr_host

//--- tb/regulator_control_registers_bench.sv
// Purpose: Self-checking bench for the regulator control register bank
// Assumes: Host model drives the register port; bench drives pins and events
// Notes:   Expected read values are queued by the driver and compared by a monitor
`timescale 1ns/100ps
module regulator_control_registers_bench;
  logic                    clk;
  logic                    sys_rst;
  logic [3:0]              ev;
  logic                    strap;
  logic [3:0]              pin;
  rcr_pkg::rcr_reg_req_t   req;
  logic [7:0]              rdata;
  rcr_pkg::rcr_supply_on_t on;
  rcr_pkg::rcr_conv_cfg_t  cfg;
  logic                    use_pin;
  logic [4:0]              step;
  logic                    busy;
  logic [7:0]              exp_q[$];
  int                      error_cnt = 0;
  int                      checked = 0;

  rcr_host u_host (.clk(clk), .reg_req(req), .reg_rdata(rdata));

  rcr_regulator_control u_dut (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .undervoltage_lockout (ev[0]),
    .warm_reset_pin_n     (!ev[1]),
    .power_on_reset_out   (ev[2]),
    .rtc_supply_low       (ev[3]),
    .core_default_pin     (strap),
    .buck1_enable_pin     (pin[0]),
    .buck2_enable_pin     (pin[1]),
    .buck3_enable_pin     (pin[2]),
    .ldo_shared_enable_pin(pin[3]),
    .reg_req              (req),
    .reg_rdata            (rdata),
    .supply_on            (on),
    .conv_cfg             (cfg),
    .core_use_pin         (use_pin),
    .core_step_code       (step),
    .core_dvm_busy        (busy)
  );

  always #20 clk = ~clk;

  task automatic chk(input logic [15:0] exp, input logic [15:0] act);
    checked++;
    if (act !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: expected %0h got %0h", $time, exp, act);
    end
  endtask : chk

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rd(a);
  endtask : rd_exp

  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  always @(u_host.got) chk({8'h00, exp_q.pop_front()}, {8'h00, u_host.got_data});

  // Generous bound; the full sequence needs well under a thousand cycles
  initial begin
    #800000;
    error_cnt++;
    results();
  end

  initial begin
    logic [7:0] w;
    logic [3:0] p;
    logic [7:0] e;
    logic [4:0] eo;
    int         n;
    clk = 1'b0;
    sys_rst = 1'b1;
    ev = 4'h0;
    strap = 1'b1;
    pin = 4'hF;
    void'($urandom(32'h8db77e9d));
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    u_host.wr(8'h08, 8'h00);
    rd_exp(8'h03, 8'h3E);
    rd_exp(8'h04, 8'hB1);
    rd_exp(8'h05, 8'h40);
    rd_exp(8'h06, 8'h1E);
    u_host.wr(8'h05, 8'h3F);
    u_host.wr(8'h06, 8'hFF);
    rd_exp(8'h05, 8'h07);
    rd_exp(8'h06, 8'h1F);
    $display("test reset and unused bits done");
    repeat (12) begin
      w = 8'($urandom);
      p = 4'($urandom);
      @(posedge clk);
      pin <= p;
      u_host.wr(8'h03, w);
      repeat (2) @(posedge clk);
      @(negedge clk);
      e = (w | {2'b00, ~p[0], ~p[1], ~p[2], ~p[3], ~p[3], 1'b0}) & 8'h3E;
      eo = {e[5] & p[0], e[4] & p[1], e[3] & p[2], e[1] & p[3], e[2] & p[3]};
      chk({11'h0, eo}, {11'h0, on});
      chk({13'h0, 3'h7 & ~{eo[3], eo[4], eo[2]}}, {13'h0, cfg.discharge});
      rd_exp(8'h03, e);
    end
    $display("test supply enables done");
    for (int i = 0; i < 4; i++) begin
      w = {i[1:0], ~i[1:0], 4'($urandom)};
      u_host.wr(8'h04, w);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({8'h00, w}, {6'h00, cfg.buck1_phase, cfg.buck2_phase, cfg.buck3_phase,
        cfg.low_ripple, cfg.forced_pwm});
      rd_exp(8'h04, w);
    end
    $display("test converter mode done");
    u_host.wr(8'h07, 8'h07);
    u_host.wr(8'h06, 8'h10);
    u_host.wr(8'h05, 8'h80);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(16'h0001, {15'h0, busy});
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(16'h0010, {11'h0, step});
    chk(16'h0000, {15'h0, use_pin});
    rd_exp(8'h05, 8'h00);
    $display("test voltage change done");
    for (int i = 0; i < 4; i++) begin
      u_host.wr(8'h06, 8'h05);
      u_host.wr(8'h05, 8'h00);
      @(posedge clk);
      strap <= i[0];
      @(posedge clk);
      ev <= 4'(1 << i);
      @(posedge clk);
      ev <= 4'h0;
      rd_exp(8'h06, i[0] ? 8'h1E : 8'h14);
      rd_exp(8'h05, 8'h40);
      chk(16'h0001, {15'h0, use_pin});
      if (i == 0) begin
        rd_exp(8'h04, 8'hB1);
        rd_exp(8'h03, 8'h3E);
      end
    end
    $display("test reset events done");
    repeat (4) @(posedge clk);
    results();
  end
endmodule : regulator_control_registers_bench
